// ---- dgcm_top.sv ----
`timescale 1ns/1ps
module dgcm_top (
  input  wire logic                 clk,          // System clock, 125 MHz
  input  wire logic                 nrst,         // Async reset, active low
  input  dgcm_pkg::dgcm_io_t        io,           // Host I/O access
  input  wire logic                 master_clear, // Master clear pulse, both groups
  input  wire logic [7:0]           req_in,       // Raw request lines, ch 4 unused
  output logic      [7:0]           ack_out,      // Acknowledge lines, polarity set
  output logic      [7:0]           req_act,      // Requests seen asserted and enabled
  output logic      [1:0]           rotate_pri,   // Rotating priority per group
  output logic      [7:0]           ch_enabled,   // Channel allowed to run
  output logic      [15:0]          ch_xfer_mode, // Mode per channel, 2 bits each
  output logic      [7:0]           ch_decrement, // Address decrement per channel
  output logic      [7:0]           ch_auto_init, // Autoinit per channel
  output logic      [15:0]          ch_xfer_type  // Type per channel, 00 on cascade
);
  import dgcm_pkg::*;

  // ****************************************************************
  // Address decode; reads decode to nothing
  // ****************************************************************
  logic       wr_lo_cmd;
  logic       wr_hi_cmd;
  logic       wr_lo_mode;
  logic       wr_hi_mode;
  logic [1:0] mode_sel;
  logic [5:0] mode_bits;

  // Only write strobes reach the registers, so a read has no side effect
  always_comb begin
    wr_lo_cmd  = io.wr && (io.addr == DGCM_LOWER_CMD_OFS);
    wr_hi_cmd  = io.wr && (io.addr == DGCM_UPPER_CMD_OFS);
    wr_lo_mode = io.wr && (io.addr == DGCM_LOWER_MODE_OFS);
    wr_hi_mode = io.wr && (io.addr == DGCM_UPPER_MODE_OFS);
    mode_sel   = io.data[DGCM_MODE_FLD_LSB-1:DGCM_MODE_SEL_LSB];
    mode_bits  = io.data[7:DGCM_MODE_FLD_LSB];
  end

  // ****************************************************************
  // Group command registers
  // ****************************************************************
  dgcm_cmd_t cmd_lo;
  dgcm_cmd_t cmd_hi;

  // Reserved bits are stored as written; software keeps them zero
  dgcm_group_cmd u_cmd_lo (
    .clk          (clk),
    .nrst         (nrst),
    .wr_en        (wr_lo_cmd),
    .wr_data      (io.data),
    .master_clear (master_clear),
    .cmd          (cmd_lo)
  );

  dgcm_group_cmd u_cmd_hi (
    .clk          (clk),
    .nrst         (nrst),
    .wr_en        (wr_hi_cmd),
    .wr_data      (io.data),
    .master_clear (master_clear),
    .cmd          (cmd_hi)
  );

  // ****************************************************************
  // Channel mode registers
  // ****************************************************************
  dgcm_mode_t mode [DGCM_NUM_CH];

  for (genvar ch = 0; ch < DGCM_NUM_CH; ch++) begin : g_mode
    localparam bit UPPER = (ch >= 4);
    logic sel;
    assign sel = (UPPER ? wr_hi_mode : wr_lo_mode) &&
                 (mode_sel == 2'(ch % 4));
    dgcm_chan_mode #(
      .IS_CASCADE (ch == DGCM_CASCADE_CH)
    ) u_mode (
      .clk     (clk),
      .nrst    (nrst),
      .wr_en   (sel),
      .wr_bits (mode_bits),
      .mode    (mode[ch])
    );
  end

  // ****************************************************************
  // Output state
  // ****************************************************************
  logic [7:0]  ack_q, ack_d;
  logic [7:0]  req_q, req_d;
  logic [1:0]  rot_q, rot_d;
  logic [7:0]  en_q, en_d;
  logic [15:0] xm_q, xm_d;
  logic [7:0]  dec_q, dec_d;
  logic [7:0]  ai_q, ai_d;
  logic [15:0] xt_q, xt_d;

  // Control values per channel; lower group follows upper disable
  always_comb begin
    dgcm_cmd_t c;
    logic      grp_off;
    logic      lvl;
    c       = cmd_lo;
    grp_off = 1'b0;
    lvl     = 1'b0;
    rot_d   = {cmd_hi.rotate, cmd_lo.rotate};
    for (int ch = 0; ch < DGCM_NUM_CH; ch++) begin
      c = (ch >= 4) ? cmd_hi : cmd_lo;
      // Lower channels reach the bus only through the cascade channel
      grp_off = c.disable_grp || cmd_hi.disable_grp;
      en_d[ch] = !grp_off;
      // Request seen asserted at the programmed level
      lvl = req_in[ch] ^ c.req_low;
      req_d[ch] = (ch != DGCM_CASCADE_CH) && lvl && !grp_off;
      // Acknowledge lines idle at their inactive level; no grant here
      ack_d[ch] = !c.ack_high;
      xm_d[2*ch +: 2] = mode[ch].xfer_mode;
      dec_d[ch] = mode[ch].decrement;
      ai_d[ch]  = mode[ch].auto_init;
      // Type is forced to verify when the channel cascades
      xt_d[2*ch +: 2] = (mode[ch].xfer_mode == DGCM_XM_CASCADE) ?
                        DGCM_XT_VERIFY : mode[ch].xfer_type;
    end
  end

  // Register outputs so every output comes from a flip-flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 8'h00;
      req_q <= 8'h00;
      rot_q <= 2'h0;
      en_q  <= 8'h00;
      xm_q  <= 16'h0000;
      dec_q <= 8'h00;
      ai_q  <= 8'h00;
      xt_q  <= 16'h0000;
    end else begin
      ack_q <= ack_d;
      req_q <= req_d;
      rot_q <= rot_d;
      en_q  <= en_d;
      xm_q  <= xm_d;
      dec_q <= dec_d;
      ai_q  <= ai_d;
      xt_q  <= xt_d;
    end
  end

  assign ack_out      = ack_q;
  assign req_act      = req_q;
  assign rotate_pri   = rot_q;
  assign ch_enabled   = en_q;
  assign ch_xfer_mode = xm_q;
  assign ch_decrement = dec_q;
  assign ch_auto_init = ai_q;
  assign ch_xfer_type = xt_q;

endmodule : dgcm_top

// ---- dgcm_pkg.sv ----
package dgcm_pkg;

  // ****************************************************************
  // I/O offsets of the write-only configuration registers
  // ****************************************************************
  localparam logic [7:0] DGCM_LOWER_CMD_OFS  = 8'h08;
  localparam logic [7:0] DGCM_LOWER_MODE_OFS = 8'h0b;
  localparam logic [7:0] DGCM_UPPER_CMD_OFS  = 8'hd0;
  localparam logic [7:0] DGCM_UPPER_MODE_OFS = 8'hd6;

  // ****************************************************************
  // Command field positions and reset values
  // ****************************************************************
  localparam int unsigned DGCM_CMD_ACK_HIGH_BIT = 7;
  localparam int unsigned DGCM_CMD_REQ_LOW_BIT  = 6;
  localparam int unsigned DGCM_CMD_ROTATE_BIT   = 4;
  localparam int unsigned DGCM_CMD_DISABLE_BIT  = 2;
  localparam logic [7:0]  DGCM_CMD_RESET        = 8'h00;

  // ****************************************************************
  // Mode fields
  // ****************************************************************
  localparam int unsigned DGCM_MODE_SEL_LSB = 0;
  localparam int unsigned DGCM_MODE_FLD_LSB = 2;
  localparam int unsigned DGCM_CASCADE_CH   = 4;
  localparam int unsigned DGCM_NUM_CH       = 8;

  typedef enum logic [1:0] {
    DGCM_XM_DEMAND  = 2'h0,
    DGCM_XM_SINGLE  = 2'h1,
    DGCM_XM_BLOCK   = 2'h2,
    DGCM_XM_CASCADE = 2'h3
  } dgcm_xfer_mode_t;

  typedef enum logic [1:0] {
    DGCM_XT_VERIFY  = 2'h0,
    DGCM_XT_WRITE   = 2'h1,
    DGCM_XT_READ    = 2'h2,
    DGCM_XT_ILLEGAL = 2'h3
  } dgcm_xfer_type_t;

  // Stored mode bits 7:2 of one channel
  typedef struct packed {
    dgcm_xfer_mode_t xfer_mode;
    logic            decrement;
    logic            auto_init;
    dgcm_xfer_type_t xfer_type;
  } dgcm_mode_t;

  localparam dgcm_mode_t DGCM_MODE_RESET   = '{DGCM_XM_DEMAND, 1'b0, 1'b0, DGCM_XT_VERIFY};
  localparam dgcm_mode_t DGCM_MODE_CASCADE = '{DGCM_XM_CASCADE, 1'b0, 1'b0, DGCM_XT_VERIFY};

  // Decoded command of one group
  typedef struct packed {
    logic ack_high;
    logic req_low;
    logic rotate;
    logic disable_grp;
  } dgcm_cmd_t;

  // Host I/O write/read strobe
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } dgcm_io_t;

  // Decode a command byte into its fields
  function automatic dgcm_cmd_t dgcm_decode_cmd(input logic [7:0] b);
    dgcm_cmd_t c;
    c.ack_high    = b[DGCM_CMD_ACK_HIGH_BIT];
    c.req_low     = b[DGCM_CMD_REQ_LOW_BIT];
    c.rotate      = b[DGCM_CMD_ROTATE_BIT];
    c.disable_grp = b[DGCM_CMD_DISABLE_BIT];
    return c;
  endfunction : dgcm_decode_cmd

endpackage : dgcm_pkg

// ---- dgcm_group_cmd.sv ----
`timescale 1ns/1ps
// One group's command register, cleared by reset or master clear
module dgcm_group_cmd (
  input  wire logic              clk,          // System clock
  input  wire logic              nrst,         // Async reset, active low
  input  wire logic              wr_en,        // Command write strobe
  input  wire logic [7:0]        wr_data,      // Written byte
  input  wire logic              master_clear, // Master clear pulse
  output dgcm_pkg::dgcm_cmd_t    cmd           // Decoded command fields
);
  import dgcm_pkg::*;

  logic [7:0] cmd_q;
  logic [7:0] cmd_d;

  // ****************************************************************
  // Next value: clear wins over a same-cycle write
  // ****************************************************************
  always_comb begin
    cmd_d = cmd_q;
    if (master_clear) begin
      cmd_d = DGCM_CMD_RESET;
    end else if (wr_en) begin
      cmd_d = wr_data;
    end
  end

  // Register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= DGCM_CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  assign cmd = dgcm_decode_cmd(cmd_q);

endmodule : dgcm_group_cmd

// ---- dgcm_chan_mode.sv ----
`timescale 1ns/1ps
// Mode register of one channel; the cascade channel is pinned
module dgcm_chan_mode #(
  parameter bit IS_CASCADE = 1'b0           // Channel fixed in cascade mode
) (
  input  wire logic             clk,        // System clock
  input  wire logic             nrst,       // Async reset, active low
  input  wire logic             wr_en,      // Mode write selecting this channel
  input  wire logic [5:0]       wr_bits,    // Written bits 7:2
  output dgcm_pkg::dgcm_mode_t  mode        // Stored mode
);
  import dgcm_pkg::*;

  dgcm_mode_t mode_q;
  dgcm_mode_t mode_d;

  // ****************************************************************
  // Next value
  // ****************************************************************
  always_comb begin
    mode_d = mode_q;
    if (IS_CASCADE) begin
      mode_d = DGCM_MODE_CASCADE;
    end else if (wr_en) begin
      mode_d = dgcm_mode_t'(wr_bits);
    end
  end

  // Register; reset is not applied by master clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= IS_CASCADE ? DGCM_MODE_CASCADE : DGCM_MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign mode = mode_q;

endmodule : dgcm_chan_mode

// ---- dgcm_top_assertions.sv ----
`timescale 1ns/1ps
// **************************************
// Port checks on the configuration block
// **************************************
module dgcm_top_assertions (
  input wire logic           clk,          // Clock
  input wire logic           nrst,         // Reset, active low
  input dgcm_pkg::dgcm_io_t  io,           // Host access
  input wire logic           master_clear, // Clear pulse
  input wire logic [7:0]     req_in,       // Raw requests
  input wire logic [7:0]     ack_out,      // Acknowledge levels
  input wire logic [7:0]     req_act,      // Seen requests
  input wire logic [1:0]     rotate_pri,   // Priority scheme
  input wire logic [7:0]     ch_enabled,   // Channel enables
  input wire logic [15:0]    ch_xfer_mode, // Modes
  input wire logic [7:0]     ch_decrement, // Stepping
  input wire logic [7:0]     ch_auto_init, // Autoinit
  input wire logic [15:0]    ch_xfer_type  // Types
);
  import dgcm_pkg::*;
  logic wl;
  logic wu;
  logic wm;
  logic q;
  // Strobes; a clear in the same cycle beats a command write
  assign wl = io.wr && io.addr == DGCM_LOWER_CMD_OFS && !master_clear;
  assign wu = io.wr && io.addr == DGCM_UPPER_CMD_OFS && !master_clear;
  assign wm = io.wr && io.addr == DGCM_UPPER_MODE_OFS && io.data[1:0] == 2'h2;
  assign q  = !io.wr && !master_clear;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ack;
    wl ##1 q |=> ack_out[3:0] == {4{!$past(io.data[7], 2)}};
  endproperty
  a_ack: assert property (p_ack) else $error("ack level wrong");
  property p_req;
    wu && !io.data[2] ##1 q |=> req_act[7:5] == ($past(req_in[7:5]) ^ {3{$past(io.data[6], 2)}});
  endproperty
  a_req: assert property (p_req) else $error("request sense wrong");
  property p_rot;
    wu ##1 q |=> rotate_pri[1] == $past(io.data[4], 2);
  endproperty
  a_rot: assert property (p_rot) else $error("priority wrong");
  property p_dis;
    wu ##1 q |=> ch_enabled[7:4] == {4{!$past(io.data[2], 2)}}
      && (!$past(io.data[2], 2) || ch_enabled[3:0] == 4'h0);
  endproperty
  a_dis: assert property (p_dis) else $error("group enable wrong");
  property p_mc;
    master_clear ##1 q |=> ch_enabled == 8'hff && ack_out == 8'hff && rotate_pri == 2'h0;
  endproperty
  a_mc: assert property (p_mc) else $error("clear not applied");
  property p_cas;
    $past(nrst) |-> ch_xfer_mode[9:8] == 2'h3 && ch_xfer_type[9:8] == 2'h0;
  endproperty
  a_cas: assert property (p_cas) else $error("cascade channel moved");
  property p_typ;
    ch_xfer_mode[1:0] == 2'h3 |-> ch_xfer_type[1:0] == 2'h0;
  endproperty
  a_typ: assert property (p_typ) else $error("cascade type not ignored");
  property p_mode;
    wm ##1 q |=> {ch_xfer_mode[13:12], ch_decrement[6], ch_auto_init[6]} == $past(io.data[7:4], 2)
      && ch_xfer_type[13:12] == ($past(io.data[7:6], 2) == 2'h3 ? 2'h0 : $past(io.data[3:2], 2));
  endproperty
  a_mode: assert property (p_mode) else $error("mode not stored");
  property p_rd;
    (io.rd && q) [*3] |-> $stable(ch_enabled) && $stable(ch_xfer_mode);
  endproperty
  a_rd: assert property (p_rd) else $error("read changed state");
endmodule : dgcm_top_assertions

bind dgcm_top dgcm_top_assertions dgcm_top_assertions_i (.clk, .nrst, .io, .master_clear,
  .req_in, .ack_out, .req_act, .rotate_pri, .ch_enabled, .ch_xfer_mode, .ch_decrement,
  .ch_auto_init, .ch_xfer_type);

// ---- dgcm_periph.sv ----
`timescale 1ns/1ps
// **************************
// Request-side peripherals
// **************************
module dgcm_periph (
  input  wire logic       clk,     // Clock
  input  wire logic [7:0] want,    // Requests to raise
  input  wire logic [1:0] act_low, // Group senses low
  output logic      [7:0] req_in   // Request lines
);
  // Lines move just after an edge, so the block never sees a mid-cycle change
  // Before the first edge the lines are unknown; reset masks that window
  always @(posedge clk) begin
    req_in <= want ^ {{4{act_low[1]}}, {4{act_low[0]}}};
  end
endmodule : dgcm_periph

// ---- dgcm_top_tb.sv ----
`timescale 1ns/1ps
// **************************
// Self-checking bench
// **************************
module dgcm_top_tb;
  import dgcm_pkg::*;
  logic        clk, nrst, master_clear;
  dgcm_io_t    io;
  logic [7:0]  want, req_in, ack_out, req_act, ch_enabled, ch_decrement, ch_auto_init;
  logic [1:0]  rotate_pri;
  logic [15:0] ch_xfer_mode, ch_xfer_type;
  logic [7:0]  cl, cu;        // Command model per group
  logic [5:0]  m [8];         // Mode model per channel
  logic [7:0]  ofs [5] = '{DGCM_LOWER_CMD_OFS, DGCM_UPPER_CMD_OFS, DGCM_LOWER_MODE_OFS,
                           DGCM_UPPER_MODE_OFS, 8'h55};
  int          n_errors, n_checks;

  dgcm_top dgcm_top_i (.clk, .nrst, .io, .master_clear, .req_in, .ack_out, .req_act,
    .rotate_pri, .ch_enabled, .ch_xfer_mode, .ch_decrement, .ch_auto_init, .ch_xfer_type);
  dgcm_periph dgcm_periph_i (.clk, .want, .act_low({cu[6], cl[6]}), .req_in);

  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Expected enables: the lower group also needs the upper one running
  function automatic logic [7:0] exp_en(input logic [7:0] lo, input logic [7:0] hi);
    return {{4{!hi[2]}}, {4{!lo[2] && !hi[2]}}};
  endfunction : exp_en

  // Expected transfer type: a cascading channel reports verify
  function automatic logic [1:0] exp_type(input logic [5:0] mb);
    return (mb[5:4] == 2'h3) ? 2'h0 : mb[1:0];
  endfunction : exp_type

  // One host access held for n cycles, then idle
  task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input int n);
    @(posedge clk);
    io <= '{w, r, a, d};
    repeat (n) @(posedge clk);
    io <= '0;
  endtask : acc

  task wr(input logic [7:0] a, input logic [7:0] d);
    int ch;
    ch = int'({a[7], d[1:0]});
    acc(1'b1, 1'b0, a, d, 1);
    if (a == DGCM_LOWER_CMD_OFS) cl = d;
    if (a == DGCM_UPPER_CMD_OFS) cu = d;
    if ((a == DGCM_LOWER_MODE_OFS || a == DGCM_UPPER_MODE_OFS) && ch != 4) m[ch] = d[7:2];
  endtask : wr

  // Clear leaves the modes alone
  task mclr();
    @(posedge clk);
    master_clear <= 1'b1;
    @(posedge clk);
    master_clear <= 1'b0;
    cl = 8'h00;
    cu = 8'h00;
  endtask : mclr

  task chk_all();
    logic [7:0] en;
    repeat (3) @(posedge clk);
    #1;
    en = exp_en(cl, cu);
    chk(ch_enabled, en);
    chk(ack_out, {{4{!cu[7]}}, {4{!cl[7]}}});
    chk(req_act, want & en & 8'hef);
    chk(rotate_pri, {cu[4], cl[4]});
    for (int c = 0; c < 8; c++) begin
      chk(ch_xfer_mode[2*c +: 2], m[c][5:4]);
      chk({ch_decrement[c], ch_auto_init[c]}, m[c][3:2]);
      chk(ch_xfer_type[2*c +: 2], exp_type(m[c]));
    end
  endtask : chk_all

  task close_out();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog, far beyond the expected run
  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  // Corner cases, then random traffic
  initial begin
    int k;
    logic [7:0] d;
    void'($urandom(32'h01122cd5));
    nrst = 1'b0;
    master_clear = 1'b0;
    io = '0;
    want = 8'h00;
    cl = 8'h00;
    cu = 8'h00;
    foreach (m[c]) m[c] = (c == 4) ? 6'h30 : 6'h00;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk_all();
    wr(8'hd0, 8'h04);
    chk_all();
    wr(8'hd6, 8'h54);
    wr(8'h0b, 8'hc4);
    wr(8'h08, 8'hd0);
    mclr();
    chk_all();
    acc(1'b0, 1'b1, DGCM_UPPER_MODE_OFS, 8'hff, 3);
    chk_all();
    for (int i = 0; i < 80; i++) begin
      want = 8'($urandom);
      k = int'($urandom % 5);
      d = 8'($urandom);
      if (k < 2) d = d & 8'hd4;
      if (k inside {2, 3} && d[3:2] == 2'h3) d[3] = 1'b0;
      wr(ofs[k], d);
      if ($urandom % 8 == 0) mclr();
      chk_all();
    end
    // Reset in mid-run restores every mode, which a master clear does not
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    cl = 8'h00;
    cu = 8'h00;
    foreach (m[c]) m[c] = (c == 4) ? 6'h30 : 6'h00;
    chk_all();
    close_out();
  end
endmodule : dgcm_top_tb
